/* File: logic/vmc_transfer_ctrl.sv */
// Functional notes
// - arbitrate, transfer, then acknowledge local requester
// - request on any of four levels
// - five selectable bus release policies
// - master drives A32, A24, A16, user spaces
// - posted master write acked at once
// - optional early request on indivisible signal
// - hold address strobe, gate by transfer size
// - deadlock flag when slave access busy
// - self access drives bus error both sides
// - slave D32/D16/D8 and four address spaces
// - slave block DMA, toggle or reject
// - restricted mode accepts supervisory only
// - slave gets local bus, then data acknowledge
// - posted slave write acked immediately
// - master modifier from function code, size, block
// - slave checks modifier against select configuration
// - drive and answer user-defined modifiers
// - release at 256-byte boundary, re-arbitrate later
// - 8-bit counters for vme, local, slave
// - slave during interleave, master only dual path
// - slave block captures then increments address
// - master block acts as local DMA master
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// posting fifo
module vmc_fifo #(parameter int W = 8, parameter int DEPTH = 8) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; logic [PW-1:0] wp; logic [PW-1:0] rp; logic [PW:0] cnt;
  } vmc_fifo_st_t;
  vmc_fifo_st_t r_reg, r_next;
  logic push, pop;
  assign inReady = r_reg.cnt != (PW+1)'(DEPTH);
  assign outValid = r_reg.cnt != '0;
  assign outData = r_reg.mem[r_reg.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wp] = inData;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop)
      r_next.rp = r_reg.rp + 1'b1;
    r_next.cnt = r_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule : vmc_fifo
// ==========================================
// transfer control
module vmc_transfer_ctrl import vmc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // configuration
  input wire vmc_cfg_t cfg,
  // local requester
  input wire logic masterSelect_n,
  input wire logic localIndivisible_n,
  input wire logic lclWrite,
  input wire logic [31:0] lclAddr,
  input wire logic [31:0] lclWrData,
  input wire logic [2:0] functionCodeIn,
  input wire logic [1:0] addressSizeSel,
  input wire logic [1:0] transferSizeIn,
  output logic lclAck,
  output logic [31:0] lclRdData,
  output logic deadlockFlag_n,
  output logic localBusError_n,
  // master block with local dma
  input wire logic blockStart,
  input wire logic blockWrite,
  input wire logic [31:0] blockVmeAddr,
  input wire logic [31:0] blockLclAddr,
  input wire logic [15:0] blockBeats,
  output logic blockBusy,
  // vme arbitration
  output logic [3:0] busReq_n,
  input wire logic busGrant_n,
  input wire logic otherReq_n,
  input wire logic busClear_n,
  // vme data transfer
  input wire vmc_vmei_t vmeIn,
  output vmc_vmeo_t vmeOut,
  // local bus as master
  input wire vmc_lbi_t lbIn,
  output vmc_lbo_t lbOut
);
  typedef enum {M_IDLE, M_ARB, M_STROBE, M_WAIT, M_END} vmc_mst_t;
  typedef enum {S_IDLE, S_LOCAL, S_ACK} vmc_slv_t;
  typedef enum {L_IDLE, L_REQ, L_ADDR, L_DATA, L_ACQ, L_END} vmc_loc_t;
  typedef struct packed {
    vmc_mst_t m; logic owned; logic pend; logic waitAck; logic [3:0] busReqN;
    logic lclAck; logic [31:0] lclRd; logic dlkN; logic lberrN; vmc_vmeo_t vo;
    vmc_req_t cur; logic curFifo; logic err; logic blkAct; logic blkWr; logic bHave;
    logic [31:0] bVme; logic [31:0] bLcl; logic [15:0] bLeft; logic ilvPend;
    logic [7:0] ilvCnt; vmc_slv_t s; logic dsArm; logic sBlkAct; logic [31:0] sAddr;
    logic sWr; vmc_loc_t l; logic lReqM; logic lReqS; logic lSrcS; logic lDoneS;
    logic [3:0] lDly; logic [31:0] lData; vmc_lbo_t lbo;
  } vmc_top_st_t;
  vmc_top_st_t r_reg, r_next;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoTake;
  vmc_req_t fifoIn, fifoOut;
  logic sizeOk, asKeep, earlyReq, slvBusy, relNow, blkWork, sOk, sBlk;
  logic [1:0] sSpace;
  logic [7:0] sInc;
  function automatic logic [5:0] amEncode(input logic [2:0] fc, input logic [1:0] asz,
                                          input logic blt, input logic [5:0] userAm);
    logic [5:0] base;
    base = (asz == SPACE_A32) ? AM_A32 : (asz == SPACE_A24) ? AM_A24 : AM_A16;
    if (asz == SPACE_USER)
      amEncode = userAm;
    else
      amEncode = base | (fc[2] ? AM_SUP : 6'h00) | (blt ? AM_BLT :
        (fc[1] && asz != SPACE_A16) ? AM_PROG : AM_DATA);
  endfunction : amEncode
  assign sizeOk = !cfg.sizeGate || transferSizeIn == cfg.sizeMatch;
  assign asKeep = cfg.asHold && !localIndivisible_n && sizeOk;
  assign earlyReq = cfg.earlyReq && !localIndivisible_n && sizeOk;
  assign slvBusy = r_reg.s != S_IDLE || r_reg.lReqS;
  // slave modifier decode
  assign sSpace = (vmeIn.am[5:4] == 2'b00) ? SPACE_A32 : (vmeIn.am[5:4] == 2'b11) ? SPACE_A24 :
    (vmeIn.am[5:4] == 2'b10) ? SPACE_A16 : SPACE_USER;
  assign sBlk = vmeIn.am[1:0] == 2'b11 && sSpace != SPACE_USER;
  assign sOk = cfg.spaceEn[sSpace] && (!cfg.supOnly || vmeIn.am[2]) &&
    !(sBlk && cfg.slvBlk == SBLK_REJECT);
  assign sInc = (cfg.slvWidth == SW_D8) ? D8_BYTES : (cfg.slvWidth == SW_D16) ? D16_BYTES :
    BEAT_BYTES;
  always_comb
  begin
    case (cfg.relMode)
      RELEASE_ON_REQUEST: relNow = !otherReq_n;
      RELEASE_WHEN_DONE: relNow = 1'b1;
      RELEASE_ON_CLEAR: relNow = !busClear_n;
      RELEASE_INDIVISIBLE: relNow = localIndivisible_n;
      default: relNow = 1'b0;
    endcase
  end
  // slave and dual path take the bus back during the interleave gap
  assign blkWork = r_reg.blkAct && !r_reg.ilvPend && !r_reg.lReqM;
  assign fifoTake = r_reg.m == M_IDLE && fifoOutValid && !r_reg.lReqM &&
    (!r_reg.blkAct || (cfg.dualPath && r_reg.ilvPend));
  assign fifoInValid = !masterSelect_n && !r_reg.pend && !slvBusy;
  assign fifoIn = '{write: lclWrite, post: lclWrite && cfg.mstPost,
    am: amEncode(functionCodeIn, addressSizeSel, 1'b0, cfg.userAm), addr: lclAddr,
    data: lclWrData};
  vmc_fifo #(.W($bits(vmc_req_t)), .DEPTH(FIFO_DEPTH)) postFifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inData(fifoIn),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(fifoTake)
  );
  always_comb
  begin
    r_next = r_reg;
    r_next.lclAck = 1'b0;
    r_next.lberrN = 1'b1;
    r_next.lDoneS = 1'b0;
    // ==========================================
    // local requester
    r_next.dlkN = !(!masterSelect_n && !r_reg.pend && slvBusy);
    if (fifoInValid && fifoInReady)
    begin
      r_next.pend = 1'b1;
      r_next.waitAck = !fifoIn.post;
      r_next.lclAck = fifoIn.post;
    end
    else if (masterSelect_n && !r_reg.waitAck)
      r_next.pend = 1'b0;
    if (blockStart && !r_reg.blkAct)
    begin
      r_next.blkAct = blockBeats != 16'h0000;
      r_next.blkWr = blockWrite;
      r_next.bVme = blockVmeAddr;
      r_next.bLcl = blockLclAddr;
      r_next.bLeft = blockBeats;
      r_next.bHave = 1'b0;
    end
    if (r_reg.ilvPend)
    begin
      r_next.ilvCnt = r_reg.ilvCnt - 8'h01;
      r_next.ilvPend = r_reg.ilvCnt != ILV_RST;
    end
    // ==========================================
    // vme master
    r_next.vo.bbsyOe = r_reg.owned;
    case (r_reg.m)
      M_IDLE:
      begin
        if (fifoTake)
        begin
          r_next.cur = fifoOut;
          r_next.curFifo = 1'b1;
          r_next.m = r_reg.owned ? M_STROBE : M_ARB;
        end
        else if (blkWork && r_reg.blkWr && !r_reg.bHave)
        begin
          r_next.lReqM = 1'b1;
          r_next.lbo.writeN = 1'b1;
          r_next.lbo.addr = r_reg.bLcl;
        end
        else if (blkWork)
        begin
          r_next.cur = '{write: r_reg.blkWr, post: 1'b0, addr: r_reg.bVme, data: r_reg.lData,
            am: amEncode(functionCodeIn, addressSizeSel, 1'b1, cfg.userAm)};
          r_next.curFifo = 1'b0;
          r_next.m = r_reg.owned ? M_STROBE : M_ARB;
        end
        else if (!r_reg.owned && earlyReq)
          r_next.m = M_ARB;
        else if (r_reg.owned && relNow && !r_reg.blkAct && !asKeep)
        begin
          r_next.owned = 1'b0;
          r_next.vo.mstOe = 1'b0;
          r_next.vo.asN = 1'b1;
        end
        if (r_reg.m == M_IDLE && r_reg.lReqM == 1'b0 && r_reg.blkAct && r_reg.bHave == 1'b0
            && r_reg.blkWr && blkWork && !fifoTake)
          r_next.bHave = 1'b0;
        r_next.busReqN = 4'hf;
      end
      M_ARB:
      begin
        r_next.busReqN = ~(4'h1 << cfg.reqLevel);
        if (!busGrant_n)
        begin
          r_next.busReqN = 4'hf;
          r_next.owned = 1'b1;
          r_next.m = (r_reg.curFifo || r_reg.blkAct) && !earlyReq ? M_STROBE : M_IDLE;
          if (fifoOutValid == 1'b0 && !r_reg.blkAct && earlyReq)
            r_next.m = M_IDLE;
          else if (r_reg.curFifo || blkWork)
            r_next.m = M_STROBE;
        end
      end
      M_STROBE:
      begin
        r_next.vo.mstOe = 1'b1;
        r_next.vo.asN = 1'b0;
        r_next.vo.dsN = 1'b0;
        r_next.vo.writeN = !r_reg.cur.write;
        r_next.vo.am = r_reg.cur.am;
        r_next.vo.addr = r_reg.cur.addr;
        r_next.vo.data = r_reg.cur.data;
        r_next.vo.dataOe = r_reg.cur.write;
        r_next.m = M_WAIT;
      end
      M_WAIT:
      begin
        if (!vmeIn.dtackN || !vmeIn.berrN)
        begin
          r_next.err = !vmeIn.berrN;
          r_next.cur.data = vmeIn.data;
          r_next.vo.dsN = 1'b1;
          r_next.vo.dataOe = 1'b0;
          r_next.vo.asN = !asKeep;
          r_next.m = M_END;
        end
      end
      default:
      begin
        if (vmeIn.dtackN && vmeIn.berrN)
        begin
          r_next.vo.mstOe = asKeep;
          r_next.m = M_IDLE;
          if (r_reg.curFifo)
          begin
            r_next.curFifo = 1'b0;
            r_next.lclRd = r_reg.cur.data;
            r_next.lclAck = !r_reg.cur.post;
            // a posted end must not free a newer request
            if (!r_reg.cur.post)
              r_next.waitAck = 1'b0;
            r_next.lberrN = !r_reg.err;
          end
          else
          begin
            r_next.bVme[7:0] = r_reg.bVme[7:0] + BEAT_BYTES;
            r_next.bLeft = r_reg.bLeft - 16'h0001;
            r_next.blkAct = r_reg.bLeft != 16'h0001 && !r_reg.err;
            r_next.bHave = 1'b0;
            if (!r_reg.blkWr)
            begin
              r_next.lReqM = 1'b1;
              r_next.lbo.writeN = 1'b0;
              r_next.lbo.addr = r_reg.bLcl;
              r_next.lbo.data = r_reg.cur.data;
            end
            else
              r_next.bLcl[7:0] = r_reg.bLcl[7:0] + BEAT_BYTES;
            if (r_reg.bVme[7:0] == LAST_BEAT)
            begin
              r_next.owned = 1'b0;
              r_next.vo.mstOe = 1'b0;
              r_next.vo.asN = 1'b1;
              r_next.ilvPend = 1'b1;
              r_next.ilvCnt = cfg.ilvCycles;
            end
          end
        end
      end
    endcase
    // ==========================================
    // vme slave
    if (vmeIn.dsN)
      r_next.dsArm = 1'b1;
    if (vmeIn.asN && r_reg.s == S_IDLE)
      r_next.sBlkAct = 1'b0;
    case (r_reg.s)
      S_IDLE:
      begin
        if (r_reg.dsArm && !vmeIn.asN && !vmeIn.dsN && !vmeIn.slaveSelN && !r_reg.lReqS)
        begin
          r_next.dsArm = 1'b0;
          if (r_reg.owned)
          begin
            r_next.vo.berrOe = 1'b1;
            r_next.lberrN = 1'b0;
            r_next.s = S_ACK;
          end
          else if (sOk)
          begin
            r_next.sBlkAct = sBlk;
            r_next.sAddr = r_reg.sBlkAct ? r_reg.sAddr : vmeIn.addr;
            r_next.sWr = !vmeIn.writeN;
            r_next.lReqS = 1'b1;
            r_next.s = S_LOCAL;
            if (!vmeIn.writeN && cfg.slvPost)
            begin
              r_next.vo.dtackOe = 1'b1;
              r_next.s = S_ACK;
            end
            r_next.lbo.writeN = vmeIn.writeN;
            r_next.lbo.addr = r_reg.sBlkAct ? r_reg.sAddr : vmeIn.addr;
            r_next.lbo.data = vmeIn.data;
          end
        end
      end
      S_LOCAL:
      begin
        if (r_reg.lDoneS)
        begin
          r_next.vo.dtackOe = 1'b1;
          r_next.vo.data = r_reg.lData;
          r_next.vo.dataOe = !r_reg.sWr;
          r_next.s = S_ACK;
        end
      end
      default:
      begin
        if (vmeIn.dsN)
        begin
          r_next.vo.dtackOe = 1'b0;
          r_next.vo.berrOe = 1'b0;
          r_next.vo.dataOe = r_reg.m == M_WAIT && r_reg.vo.dataOe;
          r_next.sAddr[7:0] = r_reg.sAddr[7:0] + sInc;
          r_next.s = S_IDLE;
        end
      end
    endcase
    // ==========================================
    // local bus master engine
    case (r_reg.l)
      L_IDLE:
      begin
        if (r_reg.lReqS || r_reg.lReqM)
        begin
          r_next.lSrcS = r_reg.lReqS;
          r_next.lbo.busReq = 1'b1;
          r_next.l = L_REQ;
        end
        else if (!(r_reg.sBlkAct && cfg.slvBlk == SBLK_DMA))
        begin
          r_next.lbo.busReq = 1'b0;
          r_next.lbo.addrStrobeN = 1'b1;
        end
      end
      L_REQ:
      begin
        if (lbIn.grant)
        begin
          r_next.lbo.addrStrobeN = 1'b0;
          r_next.lbo.dataOe = !r_reg.lbo.writeN;
          r_next.lDly = cfg.strobeDly;
          r_next.l = L_ADDR;
        end
      end
      L_ADDR:
      begin
        r_next.lDly = r_reg.lDly - 4'h1;
        if (r_reg.lDly == DLY_RST)
        begin
          r_next.lbo.dataStrobeN = 1'b0;
          r_next.l = L_DATA;
        end
      end
      L_DATA:
      begin
        if (lbIn.sizeAckN != 2'b11)
        begin
          r_next.lDly = cfg.acqDly;
          r_next.l = L_ACQ;
        end
      end
      L_ACQ:
      begin
        r_next.lDly = r_reg.lDly - 4'h1;
        if (r_reg.lDly == DLY_RST)
        begin
          r_next.lData = lbIn.data;
          r_next.lbo.dataStrobeN = 1'b1;
          r_next.lbo.dataOe = 1'b0;
          // dma style keeps the address strobe low over the whole block
          r_next.lbo.addrStrobeN = r_reg.lSrcS && r_reg.sBlkAct &&
            cfg.slvBlk == SBLK_DMA ? 1'b0 : 1'b1;
          if (r_reg.lSrcS)
          begin
            r_next.lReqS = 1'b0;
            r_next.lDoneS = 1'b1;
          end
          else
          begin
            r_next.lReqM = 1'b0;
            r_next.bHave = r_reg.lbo.writeN;
            if (!r_reg.lbo.writeN)
              r_next.bLcl[7:0] = r_reg.bLcl[7:0] + BEAT_BYTES;
          end
          r_next.l = L_END;
        end
      end
      default:
      begin
        if (lbIn.sizeAckN == 2'b11)
          r_next.l = L_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      r_reg <= '0;
      r_reg.m <= M_IDLE;
      r_reg.s <= S_IDLE;
      r_reg.l <= L_IDLE;
      r_reg.busReqN <= 4'hf;
      r_reg.dlkN <= 1'b1;
      r_reg.lberrN <= 1'b1;
      r_reg.vo.asN <= 1'b1;
      r_reg.vo.dsN <= 1'b1;
      r_reg.vo.writeN <= 1'b1;
      r_reg.lbo.addrStrobeN <= 1'b1;
      r_reg.lbo.dataStrobeN <= 1'b1;
      r_reg.lbo.writeN <= 1'b1;
    end
    else
      r_reg <= r_next;
  end
  assign lclAck = r_reg.lclAck;
  assign lclRdData = r_reg.lclRd;
  assign deadlockFlag_n = r_reg.dlkN;
  assign localBusError_n = r_reg.lberrN;
  assign blockBusy = r_reg.blkAct;
  assign busReq_n = r_reg.busReqN;
  assign vmeOut = r_reg.vo;
  assign lbOut = r_reg.lbo;
endmodule : vmc_transfer_ctrl
`default_nettype wire

/* File: logic/vmc_pkg.sv */
package vmc_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam logic [5:0] AM_A32 = 6'h08;
  localparam logic [5:0] AM_A24 = 6'h38;
  localparam logic [5:0] AM_A16 = 6'h28;
  localparam logic [5:0] AM_SUP = 6'h04;
  localparam logic [5:0] AM_DATA = 6'h01;
  localparam logic [5:0] AM_PROG = 6'h02;
  localparam logic [5:0] AM_BLT = 6'h03;
  localparam logic [1:0] SPACE_A32 = 2'h0;
  localparam logic [1:0] SPACE_A24 = 2'h1;
  localparam logic [1:0] SPACE_A16 = 2'h2;
  localparam logic [1:0] SPACE_USER = 2'h3;
  localparam logic [7:0] BEAT_BYTES = 8'h04;
  localparam logic [7:0] D16_BYTES = 8'h02;
  localparam logic [7:0] D8_BYTES = 8'h01;
  localparam logic [7:0] LAST_BEAT = 8'hfc;
  localparam logic [3:0] DLY_RST = 4'h0;
  localparam logic [7:0] ILV_RST = 8'h00;
  typedef enum logic [2:0] {RELEASE_ON_REQUEST, RELEASE_WHEN_DONE, RELEASE_ON_CLEAR,
    RELEASE_INDIVISIBLE, CAPTURE_AND_HOLD} vmc_rel_t;
  typedef enum logic [1:0] {SBLK_DMA, SBLK_TOGGLE, SBLK_REJECT} vmc_sblk_t;
  typedef enum logic [1:0] {SW_D32, SW_D16, SW_D8} vmc_width_t;
  typedef struct packed {
    logic [1:0] reqLevel; vmc_rel_t relMode; logic mstPost; logic earlyReq;
    logic asHold; logic sizeGate; logic [1:0] sizeMatch; logic [5:0] userAm;
    vmc_width_t slvWidth; vmc_sblk_t slvBlk; logic supOnly; logic slvPost;
    logic [3:0] spaceEn; logic [3:0] acqDly; logic [3:0] strobeDly;
    logic [7:0] ilvCycles; logic dualPath;
  } vmc_cfg_t;
  typedef struct packed {
    logic write; logic post; logic [5:0] am; logic [31:0] addr; logic [31:0] data;
  } vmc_req_t;
  typedef struct packed {
    logic asN; logic dsN; logic writeN; logic [5:0] am; logic [31:0] addr;
    logic [31:0] data; logic dtackN; logic berrN; logic slaveSelN;
  } vmc_vmei_t;
  typedef struct packed {
    logic mstOe; logic asN; logic dsN; logic writeN; logic [5:0] am; logic [31:0] addr;
    logic [31:0] data; logic dataOe; logic bbsyOe; logic dtackOe; logic berrOe;
  } vmc_vmeo_t;
  typedef struct packed {
    logic grant; logic [1:0] sizeAckN; logic [31:0] data;
  } vmc_lbi_t;
  typedef struct packed {
    logic busReq; logic addrStrobeN; logic dataStrobeN; logic writeN;
    logic [31:0] addr; logic [31:0] data; logic dataOe;
  } vmc_lbo_t;
endpackage : vmc_pkg

/* File: testbench/vmc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: vme arbiter and slave, local memory
module vmc_partner import vmc_pkg::*; (
  // clock, reset, pace
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slow,
  // vme side
  input wire logic [3:0] busReq_n,
  output logic busGrant_n,
  input wire vmc_vmeo_t vmeOut,
  output logic dtackN,
  output logic [31:0] vmeData,
  // local side
  input wire vmc_lbo_t lbOut,
  output vmc_lbi_t lbIn
);
  logic [31:0] mem;
  logic [31:0] lmem;
  logic [2:0] dly;
  logic gnt;
  logic [1:0] ack;
  // released lines show the inverse, so a stale copy never passes
  assign vmeData = dtackN ? ~mem : mem;
  assign lbIn = '{grant: gnt, sizeAckN: ack, data: (&ack ? ~lmem : lmem)};
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      {busGrant_n, dtackN, gnt, ack} <= 5'h1f;
      {mem, lmem, dly} <= '0;
    end
    else
    begin
      busGrant_n <= &busReq_n;
      gnt <= lbOut.busReq;
      dly <= (vmeOut.dsN && lbOut.dataStrobeN) ? 3'h0 : dly + 3'(dly != 3'h7);
      dtackN <= !(vmeOut.mstOe && !vmeOut.dsN && dly >= {1'b0, slow, 1'b1});
      ack <= (!lbOut.dataStrobeN && dly >= {1'b0, slow, 1'b1}) ? 2'h0 : 2'h3;
      if (!dtackN && !vmeOut.writeN) mem <= vmeOut.data;
      if (ack == 2'h0 && !lbOut.writeN) lmem <= lbOut.data;
    end
endmodule : vmc_partner
`default_nettype wire

/* File: testbench/vmc_transfer_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module vmc_transfer_ctrl_checker import vmc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // watched ports
  input wire vmc_cfg_t cfg,
  input wire logic masterSelect_n,
  input wire logic lclWrite,
  input wire logic lclAck,
  input wire logic deadlockFlag_n,
  input wire logic localBusError_n,
  input wire logic [3:0] busReq_n,
  input wire vmc_vmei_t vmeIn,
  input wire vmc_vmeo_t vmeOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  req_level_a: assert property (busReq_n != 4'hf |-> busReq_n == ~(4'h1 << cfg.reqLevel))
    else $error("bus request on wrong level");
  strobe_owner_a: assert property ($fell(vmeOut.asN) && vmeOut.mstOe |-> vmeOut.bbsyOe)
    else $error("address strobe without bus ownership");
  ack_pulse_a: assert property (lclAck |=> !lclAck)
    else $error("local ack longer than one cycle");
  post_ack_a: assert property ($fell(masterSelect_n) && lclWrite && cfg.mstPost
    && deadlockFlag_n && vmeIn.slaveSelN |-> ##[1:3] lclAck) else $error("posted write not acked");
  deadlock_cause_a: assert property ($fell(deadlockFlag_n) |-> $past(!masterSelect_n))
    else $error("deadlock flag without request");
  self_berr_a: assert property ($rose(vmeOut.berrOe) |-> ##[0:3] !localBusError_n)
    else $error("bus error not passed to local side");
  berr_pulse_a: assert property (!localBusError_n |=> localBusError_n)
    else $error("local bus error longer than one cycle");
  sup_only_a: assert property ($rose(vmeOut.dtackOe) && cfg.supOnly |-> vmeIn.am[2])
    else $error("user access acked in restricted mode");
  blk_reject_a: assert property ($rose(vmeOut.dtackOe) && cfg.slvBlk == SBLK_REJECT
    |-> vmeIn.am[1:0] != 2'h3) else $error("block access acked while rejected");
  dtack_cause_a: assert property ($rose(vmeOut.dtackOe) |-> $past(!vmeIn.dsN))
    else $error("dtack without data strobe");
  dtack_hold_a: assert property (vmeOut.dtackOe && vmeIn.dsN |-> ##[1:3] !vmeOut.dtackOe)
    else $error("dtack kept after strobe release");
  cover property (lclAck);
  cover property ($rose(vmeOut.dtackOe));
  cover property (!deadlockFlag_n);
  cover property ($rose(vmeOut.berrOe));
endmodule : vmc_transfer_ctrl_checker
bind vmc_transfer_ctrl vmc_transfer_ctrl_checker i_chk (.clk_sys, .rstn, .cfg, .masterSelect_n,
  .lclWrite, .lclAck, .deadlockFlag_n, .localBusError_n, .busReq_n, .vmeIn, .vmeOut);
`default_nettype wire

/* File: testbench/vmc_transfer_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench top
module vmc_transfer_ctrl_bench import vmc_pkg::*;;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  vmc_cfg_t cfg;
  logic masterSelect_n, localIndivisible_n, lclWrite, lclAck, deadlockFlag_n, localBusError_n;
  logic [31:0] lclAddr, lclWrData, lclRdData, blockVmeAddr, blockLclAddr, rd, sData, pData, d;
  logic [2:0] functionCodeIn;
  logic [1:0] addressSizeSel, transferSizeIn;
  logic blockStart, blockWrite, blockBusy, busGrant_n, otherReq_n, busClear_n, pDtack, slow;
  logic [15:0] blockBeats;
  logic [3:0] busReq_n;
  logic sAs, sDs, sWn, sSel, berrSeen;
  logic [5:0] sAm, seenAm;
  vmc_vmei_t vmeIn;
  vmc_vmeo_t vmeOut;
  vmc_lbi_t lbIn;
  vmc_lbo_t lbOut;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  always #2 clk_sys = ~clk_sys;
  // wired-or of both masters on the shared lines
  always_comb
    vmeIn = '{asN: sAs & (vmeOut.asN | ~vmeOut.mstOe), dsN: sDs & (vmeOut.dsN | ~vmeOut.mstOe),
      writeN: sWn & (vmeOut.writeN | ~vmeOut.mstOe), am: (vmeOut.mstOe ? vmeOut.am : sAm),
      addr: (vmeOut.mstOe ? vmeOut.addr : 32'h0000_0100),
      data: (vmeOut.dataOe ? vmeOut.data : (sDs ? pData : sData)),
      dtackN: pDtack, berrN: ~vmeOut.berrOe, slaveSelN: sSel};
  vmc_transfer_ctrl i_dut (.clk_sys, .rstn, .cfg, .masterSelect_n, .localIndivisible_n, .lclWrite,
    .lclAddr, .lclWrData, .functionCodeIn, .addressSizeSel, .transferSizeIn, .lclAck, .lclRdData,
    .deadlockFlag_n, .localBusError_n, .blockStart, .blockWrite, .blockVmeAddr, .blockLclAddr,
    .blockBeats, .blockBusy, .busReq_n, .busGrant_n, .otherReq_n, .busClear_n, .vmeIn, .vmeOut,
    .lbIn, .lbOut);
  vmc_partner i_partner (.clk_sys, .rstn, .slow, .busReq_n, .busGrant_n, .vmeOut,
    .dtackN(pDtack), .vmeData(pData), .lbOut, .lbIn);
  always @(posedge clk_sys)
  begin
    cyc++;
    if (!vmeOut.asN && vmeOut.mstOe) seenAm <= vmeOut.am;
    if (localBusError_n === 1'b0) berrSeen <= 1'b1;
    if (cyc == 30000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [5:0] amx(input logic [1:0] sz, input logic [2:0] fc);
    if (sz == SPACE_USER) return cfg.userAm;
    return (sz == SPACE_A32 ? AM_A32 : (sz == SPACE_A24 ? AM_A24 : AM_A16))
      | (fc[2] ? AM_SUP : 6'h00) | (fc[1] && sz != SPACE_A16 ? AM_PROG : AM_DATA);
  endfunction : amx
  task automatic mcycle(input logic wr, input logic [31:0] wd);
    {lclWrite, lclWrData, lclAddr} = {wr, wd, 32'($urandom) & 32'hffff_fffc};
    masterSelect_n = 1'b0;
    for (n = 0; n < 99 && lclAck !== 1'b1; n++) tick();
    chk({31'h0, lclAck}, 32'h1);
    rd = lclRdData;
    masterSelect_n = 1'b1;
    tick();
  endtask : mcycle
  task automatic scycle(input logic wr, input logic [5:0] am, input logic ok);
    {sWn, sAm, sData, sSel, sAs, sDs} = {~wr, am, d, 3'h0};
    for (n = 0; n < 60 && vmeOut.dtackOe !== 1'b1; n++) tick();
    chk({31'h0, vmeOut.dtackOe}, {31'h0, ok});
    rd = vmeOut.data;
    {sSel, sAs, sDs} = 3'h7;
    for (n = 0; n < 60 && (lbOut.busReq !== 1'b0 || vmeOut.dtackOe !== 1'b0); n++) tick();
    tick();
  endtask : scycle
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    {masterSelect_n, localIndivisible_n, sAs, sDs, sWn, sSel, otherReq_n, busClear_n} = 8'hff;
    {lclWrite, blockStart, blockWrite, berrSeen, slow, transferSizeIn} = 7'h00;
    {lclAddr, lclWrData, blockVmeAddr, blockLclAddr, sData, blockBeats, sAm} = '0;
    {functionCodeIn, addressSizeSel} = 5'h00;
    void'($urandom(32'h97de854e));
    cfg = '0;
    {cfg.spaceEn, cfg.userAm, cfg.ilvCycles} = {4'hf, 6'h10, 8'h04};
    {cfg.acqDly, cfg.strobeDly} = 8'($urandom) & 8'h33;
    repeat (4) tick();
    rstn = 1'b1;
    // last pass leaves the bus captured, which sets up the self access
    for (int i = 0; i < 5; i++)
    begin
      {cfg.relMode, cfg.reqLevel, cfg.mstPost} = {vmc_rel_t'(i), 2'(i), i[1]};
      {otherReq_n, busClear_n, slow, transferSizeIn} = 5'($urandom);
      {functionCodeIn, addressSizeSel, d} = {i[0], ~i[0], i[0], 2'(i), 32'($urandom)};
      mcycle(1'b1, d);
      mcycle(1'b0, d);
      chk(rd, d);
      chk({26'h0, seenAm}, {26'h0, amx(addressSizeSel, functionCodeIn)});
    end
    {sWn, sAm, sSel, sAs, sDs} = {1'b1, 6'h0d, 3'h0};
    for (n = 0; n < 20 && !berrSeen; n++) tick();
    chk({31'h0, berrSeen}, 32'h1);
    {sSel, sAs, sDs, rstn} = 4'he;
    tick();
    {rstn, cfg.relMode, cfg.slvPost, d} = {1'b1, RELEASE_WHEN_DONE, 1'b1, 32'($urandom)};
    // slave must see ds high once before the first access
    tick();
    scycle(1'b1, 6'h0d, 1'b1);
    cfg.slvPost = 1'b0;
    scycle(1'b0, 6'h3d, 1'b1);
    chk(rd, d);
    scycle(1'b0, 6'h10, 1'b1);
    cfg.supOnly = 1'b1;
    scycle(1'b0, 6'h09, 1'b0);
    scycle(1'b0, 6'h2d, 1'b1);
    {cfg.supOnly, cfg.slvBlk} = {1'b0, SBLK_REJECT};
    scycle(1'b0, 6'h0f, 1'b0);
    scycle(1'b0, 6'h0d, 1'b1);
    cfg.slvBlk = SBLK_DMA;
    {sWn, sAm, sSel, sAs, sDs} = {1'b1, 6'h0d, 3'h0};
    repeat (2) tick();
    masterSelect_n = 1'b0;
    for (n = 0; n < 20 && deadlockFlag_n !== 1'b0; n++) tick();
    chk({31'h0, deadlockFlag_n}, 32'h0);
    masterSelect_n = 1'b1;
    for (n = 0; n < 60 && vmeOut.dtackOe !== 1'b1; n++) tick();
    {sSel, sAs, sDs} = 3'h7;
    for (n = 0; n < 60 && vmeOut.dtackOe !== 1'b0; n++) tick();
    repeat (2) tick();
    mcycle(1'b0, d);
    {blockVmeAddr, blockLclAddr, blockBeats} = {32'h0000_01f8, 32'h0000_2000, 16'h0003};
    {blockWrite, blockStart} = 2'h3;
    tick();
    blockStart = 1'b0;
    for (n = 0; n < 400 && blockBusy !== 1'b0; n++) tick();
    chk({31'h0, blockBusy}, 32'h0);
    chk(i_partner.mem, d);
    tally_and_finish();
  end
endmodule : vmc_transfer_ctrl_bench
`default_nettype wire
